//--- core/tpc_pkg.sv
/*
 * Shared constants and types for the 16-bit timer with compare, capture and PWM.
 * Assumes a single 10 MHz system clock and one word-aligned register per bus word.
 */
package tpc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CAPTURE_LOW  = 8'h26;
   localparam logic [7:0] IDX_CAPTURE_HIGH = 8'h27;
   localparam logic [7:0] IDX_COMPARE_LOW  = 8'h2A;
   localparam logic [7:0] IDX_COMPARE_HIGH = 8'h2B;
   localparam logic [7:0] IDX_COUNT_LOW    = 8'h2C;
   localparam logic [7:0] IDX_COUNT_HIGH   = 8'h2D;
   localparam logic [7:0] IDX_CTRL_B       = 8'h2E;
   localparam logic [7:0] IDX_CTRL_A       = 8'h2F;
   localparam logic [7:0] IDX_FLAGS        = 8'h38;
   localparam logic [7:0] IDX_MASK         = 8'h39;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in the flag and mask registers
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMP = 1;
   localparam int FLAG_CAP = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Clock source codes
   localparam logic [2:0] CS_STOP  = 3'h0;
   localparam logic [2:0] CS_DIV1  = 3'h1;
   localparam logic [2:0] CS_DIV8  = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // Prescaler masks: tick when the masked bits are all ones
   localparam logic [9:0] PRE_MASK8    = 10'h007;
   localparam logic [9:0] PRE_MASK64   = 10'h03F;
   localparam logic [9:0] PRE_MASK256  = 10'h0FF;
   localparam logic [9:0] PRE_MASK1024 = 10'h3FF;

   ////////////////////////////////////////////////////////////////////////////
   // PWM tops
   localparam logic [15:0] TOP_8BIT  = 16'h00FF;
   localparam logic [15:0] TOP_9BIT  = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;

   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0]  RST_BYTE = 8'h00;

   // Capture filter length in samples
   localparam int FILTER_LEN = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Control register A: bit7..6 output mode, bit1..0 PWM width
   typedef struct packed {
      logic [1:0] out_mode;
      logic [3:0] rsvd;
      logic [1:0] pwm_width;
   } tpc_ctrl_a_t;

   // Control register B: filter, edge, reserved, clear-on-match, clock source
   typedef struct packed {
      logic       capture_filter_en;
      logic       capture_edge_sel;
      logic [1:0] rsvd;
      logic       clear_on_match;
      logic [2:0] clock_source;
   } tpc_ctrl_b_t;

endpackage : tpc_pkg

//--- core/tpc_timer.sv
/*
 * 16-bit timer/counter with output compare, input capture and phase-correct PWM,
 * reached over an AHB-Lite slave port.
 * Assumes one clock (hclk) and that pins arrive asynchronously.
 */
// Decided for this implementation: register access over AHB-Lite.
// What this block does
// - Source 0 stops; 1..5 tick at clock over 1,8,64,256,1024.
// - Sources 6/7 count falling/rising external pin edges.
// - External pin edges count even when the pin drives out.
// - Count high write fills latch; low write loads all 16 bits.
// - Count low read copies high byte to latch; high read returns latch.
// - After a count write, counting resumes from that value next timer tick.
// - Counts up normally, up/down in PWM; always readable and writable.
// - Compare high write goes to latch; low write updates both bytes.
// - Compare value checked continuously against count; match acts.
// - Selected capture edge copies count to capture and sets flag.
// - Capture low read moves capture high byte into latch.
// - PWM counts zero up to 255, 511 or 1023, then down to zero.
// - PWM period is timer clock over 510, 1022 or 2046.
// - PWM match uses only the low 8, 9 or 10 compare bits.
// - PWM codes 0,1 disconnect; code 2 clears up, sets down; 3 opposite.
// - PWM compare writes are buffered, taken into use when count reaches top.
// - Compare read returns the most recently written, buffered value.
// - Compare zero or top gives constant low/high for code 2, reverse for 3.
// - In PWM the overflow flag sets when the count turns at zero.
// - Request when flag, own enable and global enable all set.
// - Edge select clear picks falling capture edge, set picks rising.
// - With filter on, four equal samples are needed to capture.
// - Outside PWM, clear-on-match zeroes count the cycle after a match.
// - PWM width field: 0 off, 1/2/3 give 8/9/10-bit PWM.
`timescale 1ns/100ps
`default_nettype none

module tpc_timer (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        ext_count_pin,
   input  wire logic        capture_pin,
   input  wire logic        global_int_en,
   output logic             compare_out_pin,
   output logic             compare_out_en,
   output logic             overflow_req,
   output logic             compare_req,
   output logic             capture_req
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   tpc_pkg::tpc_ctrl_a_t ctrl_a_ff;
   tpc_pkg::tpc_ctrl_b_t ctrl_b_ff;
   logic [15:0] count_ff;
   logic [15:0] nxt_count;
   logic        dir_down_ff;
   logic        nxt_dir_down;
   logic [15:0] compare_ff;
   logic [15:0] compare_act_ff;
   logic [15:0] capture_ff;
   logic [7:0]  temp_ff;
   logic [2:0]  flags_ff;
   logic [2:0]  mask_ff;
   logic [2:0]  req_ff;
   logic [9:0]  presc_ff;
   logic        ext_s1_ff, ext_s2_ff, ext_s3_ff;
   logic        cap_s1_ff, cap_s2_ff;
   logic [2:0]  cap_hist_ff;
   logic        cap_lvl_ff, cap_lvl_d_ff;
   logic        out_ff;
   logic        match_ff;
   logic        tick;
   logic        pwm_on;
   logic [15:0] top;
   logic [15:0] cmp_m;
   logic        ovf_evt;
   logic        top_evt;
   logic        pwm_match;
   logic        cap_evt;
   logic        aphase;
   logic        dp_wr_ff, dp_rd_ff, rd_done_ff;
   logic [7:0]  dp_idx_ff;
   logic [31:0] hrdata_ff;
   logic        wr_en, rd_en;
   logic [7:0]  wbyte;
   logic [7:0]  rd_val;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign aphase    = hsel & htrans[1] & hready;
   assign hreadyout = ~(dp_rd_ff & ~rd_done_ff);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;
   assign wr_en     = dp_wr_ff;
   assign rd_en     = dp_rd_ff & ~rd_done_ff;
   assign wbyte     = hwdata[7:0];

   // Address and data phase tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_ff   <= 1'b0;
         dp_rd_ff   <= 1'b0;
         rd_done_ff <= 1'b0;
         dp_idx_ff  <= tpc_pkg::RST_BYTE;
      end else begin
         if (rd_en) begin
            rd_done_ff <= 1'b1;
         end
         if (hready) begin
            dp_wr_ff   <= aphase & hwrite;
            dp_rd_ff   <= aphase & ~hwrite;
            rd_done_ff <= 1'b0;
            dp_idx_ff  <= haddr[9:2];
         end
      end
   end

   // Read mux; count and capture high bytes return the shared latch
   always_comb begin
      rd_val = 8'h00;
      case (dp_idx_ff)
         tpc_pkg::IDX_CAPTURE_LOW:  rd_val = capture_ff[7:0];
         tpc_pkg::IDX_CAPTURE_HIGH: rd_val = temp_ff;
         tpc_pkg::IDX_COMPARE_LOW:  rd_val = compare_ff[7:0];
         tpc_pkg::IDX_COMPARE_HIGH: rd_val = compare_ff[15:8];
         tpc_pkg::IDX_COUNT_LOW:    rd_val = count_ff[7:0];
         tpc_pkg::IDX_COUNT_HIGH:   rd_val = temp_ff;
         tpc_pkg::IDX_CTRL_A:       rd_val = {ctrl_a_ff.out_mode, 4'h0, ctrl_a_ff.pwm_width};
         tpc_pkg::IDX_CTRL_B:       rd_val = {ctrl_b_ff[7:6], 2'h0, ctrl_b_ff[3:0]};
         tpc_pkg::IDX_FLAGS:        rd_val = {5'h00, flags_ff};
         tpc_pkg::IDX_MASK:         rd_val = {5'h00, mask_ff};
         default:                   rd_val = 8'h00;
      endcase
   end

   // Read data register, one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_en) begin
         hrdata_ff <= {24'h00_0000, rd_val};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared high-byte latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         temp_ff <= tpc_pkg::RST_BYTE;
      end else if (wr_en && (dp_idx_ff == tpc_pkg::IDX_COUNT_HIGH ||
                             dp_idx_ff == tpc_pkg::IDX_COMPARE_HIGH)) begin
         temp_ff <= wbyte;
      end else if (rd_en && dp_idx_ff == tpc_pkg::IDX_COUNT_LOW) begin
         temp_ff <= count_ff[15:8];
      end else if (rd_en && dp_idx_ff == tpc_pkg::IDX_CAPTURE_LOW) begin
         temp_ff <= capture_ff[15:8];
      end
   end

   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_a_ff <= tpc_pkg::RST_BYTE;
         ctrl_b_ff <= tpc_pkg::RST_BYTE;
         mask_ff   <= 3'h0;
      end else if (wr_en) begin
         if (dp_idx_ff == tpc_pkg::IDX_CTRL_A) begin
            ctrl_a_ff <= {wbyte[7:6], 4'h0, wbyte[1:0]};
         end
         if (dp_idx_ff == tpc_pkg::IDX_CTRL_B) begin
            ctrl_b_ff <= {wbyte[7:6], 2'h0, wbyte[3:0]};
         end
         if (dp_idx_ff == tpc_pkg::IDX_MASK) begin
            mask_ff <= wbyte[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_s3_ff <= 1'b0;
         cap_s1_ff <= 1'b0;
         cap_s2_ff <= 1'b0;
      end else begin
         ext_s1_ff <= ext_count_pin;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
         cap_s1_ff <= capture_pin;
         cap_s2_ff <= cap_s1_ff;
      end
   end

   // Free-running prescaler
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_ff <= 10'h000;
      end else begin
         presc_ff <= presc_ff + 10'h001;
      end
   end

   // Timer tick select
   always_comb begin
      case (ctrl_b_ff.clock_source)
         tpc_pkg::CS_STOP:     tick = 1'b0;
         tpc_pkg::CS_DIV1:     tick = 1'b1;
         tpc_pkg::CS_DIV8:     tick = &(presc_ff | ~tpc_pkg::PRE_MASK8);
         tpc_pkg::CS_DIV64:    tick = &(presc_ff | ~tpc_pkg::PRE_MASK64);
         tpc_pkg::CS_DIV256:   tick = &(presc_ff | ~tpc_pkg::PRE_MASK256);
         tpc_pkg::CS_DIV1024:  tick = &(presc_ff | ~tpc_pkg::PRE_MASK1024);
         tpc_pkg::CS_EXT_FALL: tick = ext_s3_ff & ~ext_s2_ff;
         tpc_pkg::CS_EXT_RISE: tick = ~ext_s3_ff & ext_s2_ff;
         default:              tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // PWM width and top
   assign pwm_on = ctrl_a_ff.pwm_width != 2'h0;
   always_comb begin
      case (ctrl_a_ff.pwm_width)
         2'h1:    top = tpc_pkg::TOP_8BIT;
         2'h2:    top = tpc_pkg::TOP_9BIT;
         2'h3:    top = tpc_pkg::TOP_10BIT;
         default: top = tpc_pkg::COUNT_MAX;
      endcase
   end
   assign cmp_m = pwm_on ? (compare_act_ff & top) : compare_act_ff;

   // Next count and direction
   always_comb begin
      nxt_count    = count_ff;
      nxt_dir_down = dir_down_ff;
      ovf_evt      = 1'b0;
      top_evt      = 1'b0;
      if (!pwm_on) begin
         nxt_dir_down = 1'b0;
         nxt_count    = count_ff + 16'h0001;
         ovf_evt      = count_ff == tpc_pkg::COUNT_MAX;
      end else if (!dir_down_ff) begin
         if (count_ff >= top) begin
            nxt_dir_down = 1'b1;
            nxt_count    = top - 16'h0001;
            top_evt      = 1'b1;
         end else begin
            nxt_count = count_ff + 16'h0001;
         end
      end else begin
         if (count_ff == 16'h0000) begin
            nxt_dir_down = 1'b0;
            nxt_count    = 16'h0001;
            ovf_evt      = 1'b1;
         end else begin
            nxt_count = count_ff - 16'h0001;
         end
      end
   end

   assign pwm_match = pwm_on & tick & ((nxt_count & top) == cmp_m);

   // Counter; software write wins, then clear-on-match, then ticks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_ff    <= tpc_pkg::RST_WORD;
         dir_down_ff <= 1'b0;
      end else if (wr_en && dp_idx_ff == tpc_pkg::IDX_COUNT_LOW) begin
         count_ff <= {temp_ff, wbyte};
      end else if (match_ff && !pwm_on && ctrl_b_ff.clear_on_match) begin
         count_ff <= 16'h0000;
      end else if (tick) begin
         count_ff    <= nxt_count;
         dir_down_ff <= nxt_dir_down;
      end else if (!pwm_on) begin
         dir_down_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare value and its active copy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_ff     <= tpc_pkg::RST_WORD;
         compare_act_ff <= tpc_pkg::RST_WORD;
      end else begin
         if (wr_en && dp_idx_ff == tpc_pkg::IDX_COMPARE_LOW) begin
            compare_ff <= {temp_ff, wbyte};
         end
         if (!pwm_on) begin
            compare_act_ff <= compare_ff;
         end else if (tick && top_evt) begin
            compare_act_ff <= compare_ff;
         end
      end
   end

   // Normal-mode match, seen in the same cycle as the count arrives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         match_ff <= 1'b0;
      end else begin
         match_ff <= !pwm_on && tick && (nxt_count == cmp_m);
      end
   end

   // Compare output pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_ff <= 1'b0;
      end else if (pwm_match && ctrl_a_ff.out_mode[1]) begin
         if (cmp_m == 16'h0000) begin
            out_ff <= ctrl_a_ff.out_mode[0];
         end else if (cmp_m == top) begin
            out_ff <= ~ctrl_a_ff.out_mode[0];
         end else begin
            out_ff <= ctrl_a_ff.out_mode[0] ^ dir_down_ff;
         end
      end else if (match_ff) begin
         case (ctrl_a_ff.out_mode)
            2'h1:    out_ff <= ~out_ff;
            2'h2:    out_ff <= 1'b0;
            2'h3:    out_ff <= 1'b1;
            default: out_ff <= out_ff;
         endcase
      end
   end
   assign compare_out_pin = out_ff;
   assign compare_out_en  = pwm_on ? ctrl_a_ff.out_mode[1] : (ctrl_a_ff.out_mode != 2'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Capture filter and edge detect
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap_hist_ff  <= 3'h0;
         cap_lvl_ff   <= 1'b0;
         cap_lvl_d_ff <= 1'b0;
      end else begin
         cap_hist_ff  <= {cap_hist_ff[1:0], cap_s2_ff};
         cap_lvl_d_ff <= cap_lvl_ff;
         if (!ctrl_b_ff.capture_filter_en) begin
            cap_lvl_ff <= cap_s2_ff;
         end else if ({cap_hist_ff, cap_s2_ff} == 4'hF) begin
            cap_lvl_ff <= 1'b1;
         end else if ({cap_hist_ff, cap_s2_ff} == 4'h0) begin
            cap_lvl_ff <= 1'b0;
         end
      end
   end
   assign cap_evt = ctrl_b_ff.capture_edge_sel ? (cap_lvl_ff & ~cap_lvl_d_ff)
                                               : (~cap_lvl_ff & cap_lvl_d_ff);

   // Capture register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture_ff <= tpc_pkg::RST_WORD;
      end else if (cap_evt) begin
         capture_ff <= count_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags: write one clears, a set in the same cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_ff <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (wr_en && dp_idx_ff == tpc_pkg::IDX_FLAGS && wbyte[i]) begin
               flags_ff[i] <= 1'b0;
            end
         end
         if (tick && ovf_evt) begin
            flags_ff[tpc_pkg::FLAG_OVF] <= 1'b1;
         end
         if (match_ff || pwm_match) begin
            flags_ff[tpc_pkg::FLAG_CMP] <= 1'b1;
         end
         if (cap_evt) begin
            flags_ff[tpc_pkg::FLAG_CAP] <= 1'b1;
         end
      end
   end

   // Request outputs gated by masks and global enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_ff <= 3'h0;
      end else begin
         req_ff <= flags_ff & mask_ff & {3{global_int_en}};
      end
   end
   assign overflow_req = req_ff[tpc_pkg::FLAG_OVF];
   assign compare_req  = req_ff[tpc_pkg::FLAG_CMP];
   assign capture_req  = req_ff[tpc_pkg::FLAG_CAP];

endmodule // tpc_timer

`default_nettype wire

//--- test/tb_tpc_timer.sv
/* Bench for tpc_timer: registers, counting, capture, PWM.
 * Assumes tpc_pin_drv and tpc_timer_props. */
`timescale 1ns/100ps
`default_nettype none

module tb_tpc_timer;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, gie;
   logic        ext_pin, cap_pin, cmp_pin, cmp_en, ovf_req, cmp_req, cap_req;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0]  rb;
   logic [15:0] v;
   logic [15:0] pex[4] = '{16'h0000, 16'h01FE, 16'h03FE, 16'h07FE};
   int          lo[6] = '{0, 2047, 255, 31, 7, 1};
   int          hi[6] = '{0, 2058, 258, 33, 9, 3};
   int          mismatches, num_checks, p;
   localparam logic [7:0] TH = tpc_pkg::IDX_COUNT_HIGH, TL = tpc_pkg::IDX_COUNT_LOW;
   localparam logic [7:0] OH = tpc_pkg::IDX_COMPARE_HIGH, IL = tpc_pkg::IDX_CAPTURE_LOW;
   localparam logic [7:0] CA = tpc_pkg::IDX_CTRL_A, CB = tpc_pkg::IDX_CTRL_B;
   localparam logic [7:0] FL = tpc_pkg::IDX_FLAGS;

   // Clock; the one slave drives the bus ready
   initial hclk = 1'b0;
   always #50 hclk = ~hclk;
   assign hready = hreadyout;

   tpc_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_count_pin(ext_pin),
      .capture_pin(cap_pin), .global_int_en(gie), .compare_out_pin(cmp_pin),
      .compare_out_en(cmp_en), .overflow_req(ovf_req), .compare_req(cmp_req),
      .capture_req(cap_req));
   tpc_pin_drv u_pins (.hclk(hclk), .ext_count_pin(ext_pin), .capture_pin(cap_pin));

   ////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One single word transfer; read byte left in rb
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      do @(negedge hclk); while (hready !== 1'b1);
      @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(negedge hclk); while (hready !== 1'b1);
      rb = hrdata[7:0];
      @(posedge hclk);
   endtask
   // High byte first, then low
   task automatic wr16(input logic [7:0] hidx, input logic [15:0] val);
      bus(1'b1, hidx, val[15:8]);
      bus(1'b1, hidx - 8'h01, val[7:0]);
   endtask
   // Low byte first, then high
   task automatic rd16(input logic [7:0] lidx);
      bus(1'b0, lidx, 8'h00);
      v[7:0] = rb;
      bus(1'b0, lidx + 8'h01, 8'h00);
      v[15:8] = rb;
   endtask
   // Clocks per output period
   task automatic per(output int n);
      time t0;
      @(posedge cmp_pin);
      @(posedge cmp_pin);
      t0 = $time;
      @(posedge cmp_pin);
      n = int'(($time - t0) / 100);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      gie = 1'b1;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b1, 8'h30, 8'h5A);
      foreach (pex[i]) begin
         rd16(IL + 8'(2 * i));
         chk("reset", v, 16'h0000);
      end
      bus(1'b1, tpc_pkg::IDX_MASK, 8'h07);
      wr16(TH, 16'h1234);
      rd16(TL);
      chk("count", v, 16'h1234);
      bus(1'b1, TH, 8'hAB);
      rd16(TL);
      chk("latch", v, 16'h1234);
      wr16(OH, 16'h5678);
      bus(1'b1, IL, 8'hFF);
      rd16(OH - 8'h01);
      chk("compare", v, 16'h5678);
      // Every clock source: prescaled over a window, external by pulses
      for (int i = 0; i < 8; i++) begin
         wr16(TH, 16'h0000);
         bus(1'b1, CB, 8'(i));
         if (i < 6) repeat (2048) @(posedge hclk);
         else begin
            u_pins.pulse_ext(5);
            repeat (6) @(posedge hclk);
         end
         bus(1'b1, CB, 8'h00);
         rd16(TL);
         if (i < 6)
            chk("presc", {15'h0, v >= 16'(lo[i]) && v <= 16'(hi[i])}, 16'h0001);
         else
            chk("ext_count", v, 16'h0005);
      end
      // Capture on rising, then falling edge
      for (int e = 0; e < 2; e++) begin
         wr16(TH, 16'h1234 + 16'(e));
         bus(1'b1, CB, (e == 0) ? 8'h40 : 8'h00);
         u_pins.drive_cap(e == 0, 10);
         rd16(IL);
         chk("capture", v, 16'h1234 + 16'(e));
      end
      bus(1'b0, FL, 8'h00);
      chk("cap_flag", {15'h0, rb[tpc_pkg::FLAG_CAP]}, 16'h0001);
      chk("cap_req", {15'h0, cap_req}, 16'h0001);
      bus(1'b1, FL, 8'h07);
      repeat (2) @(posedge hclk);
      chk("cap_req_clr", {15'h0, cap_req}, 16'h0000);
      // Filtered capture: glitch ignored, steady level taken
      wr16(TH, 16'h3456);
      bus(1'b1, CB, 8'hC0);
      u_pins.drive_cap(1'b1, 1);
      u_pins.drive_cap(1'b0, 10);
      rd16(IL);
      chk("cap_glitch", v, 16'h1235);
      u_pins.drive_cap(1'b1, 12);
      rd16(IL);
      chk("cap_filter", v, 16'h3456);
      // Clear on match
      wr16(OH, 16'h0010);
      wr16(TH, 16'h0000);
      bus(1'b1, CB, 8'h09);
      repeat (100) @(posedge hclk);
      bus(1'b1, CB, 8'h00);
      rd16(TL);
      chk("ctc", {15'h0, v <= 16'h0010}, 16'h0001);
      bus(1'b0, FL, 8'h00);
      chk("cmp_flag", {15'h0, rb[tpc_pkg::FLAG_CMP]}, 16'h0001);
      // PWM periods per width, then output codes
      wr16(OH, 16'h0040);
      for (int w = 1; w < 4; w++) begin
         bus(1'b1, CA, 8'h80 | 8'(w));
         bus(1'b1, CB, 8'h01);
         per(p);
         chk("period", p[15:0], pex[w]);
      end
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, CA, {2'(c), 6'h03});
         @(posedge hclk);
         chk("out_en", {15'h0, cmp_en}, 16'(c > 1));
      end
      bus(1'b1, CA, 8'h83);
      wr16(OH, 16'h0123);
      rd16(OH - 8'h01);
      chk("pwm_cmp_read", v, 16'h0123);
      for (int k = 0; k < 2; k++) begin
         wr16(OH, (k == 0) ? 16'h0000 : tpc_pkg::TOP_10BIT);
         repeat (4200) @(posedge hclk);
         repeat (8) begin
            repeat (256) @(posedge hclk);
            chk("pwm_level", {15'h0, cmp_pin}, 16'(k));
         end
      end
      bus(1'b0, FL, 8'h00);
      chk("ovf_flag", {15'h0, rb[tpc_pkg::FLAG_OVF]}, 16'h0001);
      chk("ovf_req", {15'h0, ovf_req}, 16'h0001);
      gie <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("ovf_req_off", {15'h0, ovf_req}, 16'h0000);
      summarize();
   end

   // Watchdog against a hung wait
   initial begin
      repeat (80000) @(posedge hclk);
      mismatches++;
      summarize();
   end
endmodule // tb_tpc_timer

bind tpc_timer tpc_timer_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .capture_pin(capture_pin),
   .global_int_en(global_int_en), .overflow_req(overflow_req),
   .compare_req(compare_req), .capture_req(capture_req));

`default_nettype wire

//--- test/tpc_pin_drv.sv
/* Pin-side partner: drives the external count pin and the capture pin.
 * Assumes calls from the bench right after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none

module tpc_pin_drv (
   input  wire logic hclk,
   output logic      ext_count_pin,
   output logic      capture_pin
);
   // Both pins idle low
   initial begin
      ext_count_pin = 1'b0;
      capture_pin   = 1'b0;
   end

   ////////////////////////////////////////
   // Whole pulses, each level held several clocks
   task automatic pulse_ext(input int n);
      repeat (n) begin
         @(posedge hclk);
         ext_count_pin <= 1'b1;
         repeat (3) @(posedge hclk);
         ext_count_pin <= 1'b0;
         repeat (2) @(posedge hclk);
      end
   endtask
   // New capture level, then held
   task automatic drive_cap(input logic lvl, input int hold);
      @(posedge hclk);
      capture_pin <= lvl;
      repeat (hold) @(posedge hclk);
   endtask
endmodule // tpc_pin_drv

`default_nettype wire

//--- test/tpc_timer_props.sv
/* Checker for the tpc_timer ports: bus waits, read data, request gating.
 * Assumes hready tied to hreadyout and the request mask set before captures. */
`timescale 1ns/100ps
`default_nettype none

module tpc_timer_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        capture_pin,
   input wire logic        global_int_en,
   input wire logic        overflow_req,
   input wire logic        compare_req,
   input wire logic        capture_req
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [3:0] since_ff;
   logic       pin_ff;

   // Clocks since the capture pin last moved, saturating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since_ff <= 4'hF;
         pin_ff   <= 1'b0;
      end else begin
         pin_ff   <= capture_pin;
         since_ff <= (capture_pin != pin_ff) ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
      end
   end

   ////////////////////////////////////////
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("hresp");
   property p_rd_wait;
      hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("rd wait");
   property p_wr_ready;
      hsel && htrans[1] && hready && hwrite |=> hreadyout;
   endproperty
   a_wr_ready: assert property (p_wr_ready) else $error("wr wait");
   property p_wait_cause;
      $fell(hreadyout) |-> $past(hsel) && !$past(hwrite);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("bad wait");
   property p_rdata_hi;
      $rose(hreadyout) |-> hrdata[31:8] == 24'h0;
   endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("rdata hi");
   property p_ovf_gate;
      overflow_req |-> $past(global_int_en);
   endproperty
   a_ovf_gate: assert property (p_ovf_gate) else $error("ovf gate");
   property p_cmp_gate;
      compare_req |-> $past(global_int_en);
   endproperty
   a_cmp_gate: assert property (p_cmp_gate) else $error("cmp gate");
   property p_cap_gate;
      capture_req |-> $past(global_int_en);
   endproperty
   a_cap_gate: assert property (p_cap_gate) else $error("cap gate");
   property p_cap_time;
      $rose(capture_req) |-> since_ff <= 4'hC;
   endproperty
   a_cap_time: assert property (p_cap_time) else $error("cap late");
endmodule // tpc_timer_props

`default_nettype wire
